// file: rtl/and_bitclear_condbranch_exec.sv
// Executor for the AND with file, bit clear and six conditional branch instructions
//
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
module and_bitclear_condbranch_exec
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic [15:0] INSTR_WORD,
  input  wire logic        INSTR_VALID,
  output logic             INSTR_READY,
  output logic      [15:0] PC_OUT,
  output logic      [7:0]  W_OUT,
  output logic      [4:0]  STATUS_OUT,
  input  wire logic [2:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed
  {
    exec_pkg::phase_e phase;
    logic [15:0]      instr;
    logic             busy;
    logic             ready;
    logic [7:0]       w;
    logic [4:0]       status;
    logic [3:0]       bank_select_register;
    logic [15:0]      pc;
    logic             ext;
    logic [11:0]      idx;
    logic [11:0]      faddr;
    logic [7:0]       result;
    logic             take;
    logic [7:0]       rdata;
  } state_s;

  state_s      st;
  state_s      next_st;
  logic [7:0]  mem_rdata;
  logic        mem_we;
  logic [7:0]  mem_wdata;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_and(input logic [15:0] iw);
    is_and = (iw[15:10] == exec_pkg::OP_AND_WITH_FILE);
  endfunction

  function automatic logic is_bcf(input logic [15:0] iw);
    is_bcf = (iw[15:12] == exec_pkg::OP_BIT_CLEAR_FILE);
  endfunction

  function automatic logic is_branch(input logic [15:0] iw);
    logic [7:0] op;
    op = iw[15:8];
    is_branch = (op == exec_pkg::OP_BR_CARRY_SET) || (op == exec_pkg::OP_BR_CARRY_CLEAR) ||
                (op == exec_pkg::OP_BR_NEG_SET) || (op == exec_pkg::OP_BR_NEG_CLEAR) ||
                (op == exec_pkg::OP_BR_OVF_CLEAR) || (op == exec_pkg::OP_BR_ZERO_CLEAR);
  endfunction

  // Branch condition from opcode and flags
  function automatic logic branch_cond(input logic [7:0] op, input logic [4:0] sr);
    branch_cond = 1'b0;
    if (op == exec_pkg::OP_BR_CARRY_SET)
      branch_cond = sr[exec_pkg::FLAG_CARRY];
    else if (op == exec_pkg::OP_BR_CARRY_CLEAR)
      branch_cond = !sr[exec_pkg::FLAG_CARRY];
    else if (op == exec_pkg::OP_BR_NEG_SET)
      branch_cond = sr[exec_pkg::FLAG_NEG];
    else if (op == exec_pkg::OP_BR_NEG_CLEAR)
      branch_cond = !sr[exec_pkg::FLAG_NEG];
    else if (op == exec_pkg::OP_BR_OVF_CLEAR)
      branch_cond = !sr[exec_pkg::FLAG_OVF];
    else if (op == exec_pkg::OP_BR_ZERO_CLEAR)
      branch_cond = !sr[exec_pkg::FLAG_ZERO];
  endfunction

  // File address from field, access bit, bank and index base
  function automatic logic [11:0] file_addr(input logic [15:0] iw, input logic [3:0] bank,
                                            input logic ext_on, input logic [11:0] base);
    logic [7:0] f;
    f = iw[7:0];
    if (iw[exec_pkg::ACCESS_BIT])
      file_addr = {bank, f};
    else if (ext_on && (f <= exec_pkg::INDEX_LIMIT))
      file_addr = base + {4'h0, f};
    else if (f < exec_pkg::ACCESS_SPLIT)
      file_addr = {exec_pkg::ACCESS_LOW, f};
    else
      file_addr = {exec_pkg::ACCESS_HIGH, f};
  endfunction

  // ****************************************
  // File register memory
  // ****************************************
  file_ram i_file_ram
  (
    .clk   (SYS_CLK),
    .addr  (st.faddr),
    .we    (mem_we),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // File write in the write phase for AND to file and bit clear
  assign mem_we    = (st.phase == exec_pkg::PH_WRITE) && st.busy &&
                     ((is_and(st.instr) && st.instr[exec_pkg::DEST_BIT]) || is_bcf(st.instr));
  assign mem_wdata = st.result;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    // Register port writes
    if (REG_WR)
    begin
      if (REG_ADDR == exec_pkg::REG_WORK)
        next_st.w = REG_WDATA;
      else if (REG_ADDR == exec_pkg::REG_STATUS)
        next_st.status = REG_WDATA[4:0];
      else if (REG_ADDR == exec_pkg::REG_BANK_SEL)
        next_st.bank_select_register = REG_WDATA[3:0];
      else if (REG_ADDR == exec_pkg::REG_PC_LOW)
        next_st.pc[7:0] = REG_WDATA;
      else if (REG_ADDR == exec_pkg::REG_PC_HIGH)
        next_st.pc[15:8] = REG_WDATA;
      else if (REG_ADDR == exec_pkg::REG_CONTROL)
        next_st.ext = REG_WDATA[exec_pkg::CTRL_EXT_BIT];
      else if (REG_ADDR == exec_pkg::REG_INDEX_LOW)
        next_st.idx[7:0] = REG_WDATA;
      else
        next_st.idx[11:8] = REG_WDATA[3:0];
    end
    // Register port reads, answered next cycle
    next_st.rdata = 8'h00;
    if (REG_RD)
    begin
      if (REG_ADDR == exec_pkg::REG_WORK)
        next_st.rdata = st.w;
      else if (REG_ADDR == exec_pkg::REG_STATUS)
        next_st.rdata = {3'h0, st.status};
      else if (REG_ADDR == exec_pkg::REG_BANK_SEL)
        next_st.rdata = {4'h0, st.bank_select_register};
      else if (REG_ADDR == exec_pkg::REG_PC_LOW)
        next_st.rdata = st.pc[7:0];
      else if (REG_ADDR == exec_pkg::REG_PC_HIGH)
        next_st.rdata = st.pc[15:8];
      else if (REG_ADDR == exec_pkg::REG_CONTROL)
        next_st.rdata = {7'h00, st.ext};
      else if (REG_ADDR == exec_pkg::REG_INDEX_LOW)
        next_st.rdata = st.idx[7:0];
      else
        next_st.rdata = {4'h0, st.idx[11:8]};
    end
    // Four phase sequencer
    next_st.ready = 1'b0;
    case (st.phase)
      exec_pkg::PH_DECODE:
      begin
        next_st.phase = exec_pkg::PH_READ;
        next_st.busy  = st.ready && INSTR_VALID;
        next_st.take  = 1'b0;
        if (st.ready && INSTR_VALID)
        begin
          next_st.instr = INSTR_WORD;
          next_st.pc    = st.pc + exec_pkg::PC_STEP;
          next_st.faddr = file_addr(INSTR_WORD, st.bank_select_register, st.ext, st.idx);
        end
      end
      exec_pkg::PH_READ:
      begin
        next_st.phase = exec_pkg::PH_PROCESS;
      end
      exec_pkg::PH_PROCESS:
      begin
        next_st.phase = exec_pkg::PH_WRITE;
        if (is_and(st.instr))
          next_st.result = st.w & mem_rdata;
        else
          next_st.result = mem_rdata & ~(8'h01 << st.instr[exec_pkg::BITSEL_LSB +: 3]);
        next_st.take = st.busy && is_branch(st.instr) && branch_cond(st.instr[15:8], st.status);
      end
      exec_pkg::PH_WRITE:
      begin
        next_st.phase = exec_pkg::PH_DECODE;
        next_st.ready = !st.take;
        if (st.busy && is_and(st.instr))
        begin
          if (!st.instr[exec_pkg::DEST_BIT])
            next_st.w = st.result;
          next_st.status[exec_pkg::FLAG_ZERO] = (st.result == 8'h00);
          next_st.status[exec_pkg::FLAG_NEG]  = st.result[7];
        end
        if (st.take)
          next_st.pc = st.pc + {{7{st.instr[7]}}, st.instr[7:0], 1'b0};
      end
      default:
      begin
        next_st.phase = exec_pkg::PH_DECODE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      st        <= '0;
      st.phase  <= exec_pkg::PH_DECODE;
      st.pc     <= exec_pkg::PC_RESET;
      st.ready  <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state
  assign INSTR_READY = st.ready;
  assign PC_OUT      = st.pc;
  assign W_OUT       = st.w;
  assign STATUS_OUT  = st.status;
  assign REG_RDATA   = st.rdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  logic w_phase;
  assign w_phase = (st.phase == exec_pkg::PH_WRITE) && st.busy;

  a_phase_order: assert property
    ((st.phase == exec_pkg::PH_DECODE) |=> (st.phase == exec_pkg::PH_READ) ##1
     (st.phase == exec_pkg::PH_PROCESS) ##1 (st.phase == exec_pkg::PH_WRITE) ##1
     (st.phase == exec_pkg::PH_DECODE))
    else $error("phase order broken");

  a_and_value: assert property
    ((st.phase == exec_pkg::PH_PROCESS) && st.busy && is_and(st.instr)
     |=> st.result == ($past(st.w) & $past(mem_rdata)))
    else $error("and result wrong");

  a_and_to_work: assert property
    (w_phase && is_and(st.instr) && !st.instr[9] && !REG_WR |=> st.w == $past(st.result))
    else $error("and result not in working register");

  a_and_to_file: assert property
    (w_phase && is_and(st.instr) |-> mem_we == st.instr[9])
    else $error("and destination wrong");

  a_and_flags: assert property
    (w_phase && is_and(st.instr) && !REG_WR |=> st.status[3] == $past(st.status[3]) &&
     st.status[1:0] == $past(st.status[1:0]) && st.status[2] == ($past(st.result) == 8'h00) &&
     st.status[4] == $past(st.result[7]))
    else $error("and flags wrong");

  a_bank_addr: assert property
    ((st.phase == exec_pkg::PH_READ) && st.busy && st.instr[8] |-> st.faddr == {st.bank_select_register, st.instr[7:0]})
    else $error("banked address wrong");

  a_index_addr: assert property
    ((st.phase == exec_pkg::PH_DECODE) && st.ready && INSTR_VALID && !INSTR_WORD[8] && st.ext &&
     INSTR_WORD[7:0] < 8'h60 |=> st.faddr == $past(st.idx) + {4'h0, $past(INSTR_WORD[7:0])})
    else $error("indexed address wrong");

  a_bit_clear: assert property
    ((st.phase == exec_pkg::PH_PROCESS) && st.busy && is_bcf(st.instr) |=>
     st.result[st.instr[11:9]] == 1'b0 && (st.result | (8'h01 << st.instr[11:9])) ===
     ($past(mem_rdata) | (8'h01 << st.instr[11:9]))) // Fresh cells may hold unset bits
    else $error("bit clear wrong");

  a_flags_hold: assert property
    (w_phase && (is_bcf(st.instr) || is_branch(st.instr)) && !REG_WR |=> st.status == $past(st.status))
    else $error("flags changed");

  a_carry_branch: assert property
    (w_phase && st.instr[15:9] == 7'h71 |-> st.take == (st.status[0] ^ st.instr[8]))
    else $error("carry branch wrong");

  a_neg_branch: assert property
    (w_phase && st.instr[15:9] == 7'h73 |-> st.take == (st.status[4] ^ st.instr[8]))
    else $error("negative branch wrong");

  a_ovz_branch: assert property
    (w_phase && (st.instr[15:8] == 8'he5 && st.take != !st.status[3] ||
     st.instr[15:8] == 8'he1 && st.take != !st.status[2]) |-> 1'b0)
    else $error("overflow or zero branch wrong");

  a_branch_target: assert property
    (w_phase && st.take && !REG_WR |=> st.pc == $past(st.pc) + {{7{$past(st.instr[7])}}, $past(st.instr[7:0]), 1'b0})
    else $error("branch target wrong");

  a_taken_idle: assert property
    (w_phase && st.take |=> !st.ready [*4] ##1 st.ready)
    else $error("taken branch did not idle one cycle");

  a_untaken_one: assert property
    (w_phase && !st.take && !REG_WR |=> st.ready && st.pc == $past(st.pc))
    else $error("one cycle instruction stalled");

  c_and_file: cover property (w_phase && is_and(st.instr) && st.instr[9]);
  c_bit_clear: cover property (w_phase && is_bcf(st.instr));
  c_branch_taken: cover property (w_phase && st.take);
  c_branch_skip: cover property (w_phase && is_branch(st.instr) && !st.take);

endmodule

// file: common/exec_pkg.sv
// Constants, phase states and field layouts for the AND, bit-clear and branch executor
// Function
// - A word 0001 01da ffff ffff is an AND of the working register with the addressed file register.
// - The AND result goes to the working register when d is 0 and back to the file register when d is 1.
// - The AND updates only the negative and zero flags; carry, digit carry and overflow keep their values.
// - Access bit 0 selects the access bank; access bit 1 joins the bank select register with the file field.
// - Access bit 0 with the extended set on and a file field of at most 95 uses indexed literal offset addressing.
// - A word 1001 bbba ffff ffff clears bit b of the addressed file register and keeps the other bits.
// - The bit clear and all six conditional branches leave every status flag as it was.
// - A word 1110 0010 nnnn nnnn branches only when carry is 1.
// - A word 1110 0011 nnnn nnnn branches only when carry is 0.
// - A word 1110 0110 nnnn nnnn branches only when negative is 1.
// - A word 1110 0111 nnnn nnnn branches only when negative is 0.
// - A word with upper byte 1110 0101 branches only when overflow is 0, the lower byte being the offset.
// - A word 1110 0001 nnnn nnnn branches only when zero is 0.
// - A taken branch loads the already incremented counter plus twice the sign-extended 8-bit offset.
// - A branch not taken takes one cycle with no last-phase write; a taken one writes the counter then idles a cycle.
package exec_pkg;

  // ****************************************
  // Phase states of one instruction cycle
  // ****************************************
  typedef enum logic [3:0]
  {
    PH_DECODE  = 4'b0001,
    PH_READ    = 4'b0010,
    PH_PROCESS = 4'b0100,
    PH_WRITE   = 4'b1000
  } phase_e;

  // ****************************************
  // Opcode patterns
  // ****************************************
  localparam logic [5:0] OP_AND_WITH_FILE   = 6'h05;
  localparam logic [3:0] OP_BIT_CLEAR_FILE  = 4'h9;
  localparam logic [7:0] OP_BR_CARRY_SET    = 8'he2;
  localparam logic [7:0] OP_BR_CARRY_CLEAR  = 8'he3;
  localparam logic [7:0] OP_BR_NEG_SET      = 8'he6;
  localparam logic [7:0] OP_BR_NEG_CLEAR    = 8'he7;
  localparam logic [7:0] OP_BR_OVF_CLEAR    = 8'he5;
  localparam logic [7:0] OP_BR_ZERO_CLEAR   = 8'he1;

  // ****************************************
  // Instruction field positions
  // ****************************************
  localparam int DEST_BIT   = 9;
  localparam int ACCESS_BIT = 8;
  localparam int BITSEL_LSB = 9;

  // ****************************************
  // Status flag positions
  // ****************************************
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DIGIT = 1;
  localparam int FLAG_ZERO  = 2;
  localparam int FLAG_OVF   = 3;
  localparam int FLAG_NEG   = 4;

  // ****************************************
  // Addressing constants
  // ****************************************
  localparam logic [7:0] INDEX_LIMIT   = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0] ACCESS_HIGH   = 4'hf;
  localparam logic [3:0] ACCESS_LOW    = 4'h0;
  localparam int         FILE_AW       = 12;

  // ****************************************
  // Register port map and reset values
  // ****************************************
  localparam logic [2:0] REG_WORK      = 3'h0;
  localparam logic [2:0] REG_STATUS    = 3'h1;
  localparam logic [2:0] REG_BANK_SEL  = 3'h2;
  localparam logic [2:0] REG_PC_LOW    = 3'h3;
  localparam logic [2:0] REG_PC_HIGH   = 3'h4;
  localparam logic [2:0] REG_CONTROL   = 3'h5;
  localparam logic [2:0] REG_INDEX_LOW = 3'h6;
  localparam logic [2:0] REG_INDEX_HI  = 3'h7;
  localparam int         CTRL_EXT_BIT  = 0;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [15:0] PC_STEP      = 16'h0002;

endpackage

// file: rtl/file_ram.sv
// Data memory holding the file registers, with registered read data
`timescale 1ns/100ps
module file_ram
(
  input  wire logic        clk,
  input  wire logic [11:0] addr,
  input  wire logic        we,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);

  logic [7:0] mem [0:4095];

  // Write and registered read of the old contents on the same address
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// file: verification/fetch_model.sv
// Fetch stage model that hands queued instruction words to the executor
`timescale 1ns/100ps
module fetch_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ready,
  input  wire logic [3:0]  slow,
  output logic             valid,
  output logic      [15:0] word
);
  logic [15:0] fifo [$];
  int          idle = 0;

  // Queue one word for issue
  task automatic load(input logic [15:0] wd);
    fifo.push_back(wd);
  endtask

  // Idle lines until the first edge
  initial
  begin
    valid = 1'b0;
    word  = 16'h0000;
  end

  // Hold a word until taken, then issue the next after slow idle cycles
  always @(posedge clk)
  begin
    if (rst)
      valid <= 1'b0;
    else if (!valid || ready)
    begin
      if (fifo.size() != 0 && idle >= slow)
      begin
        valid <= 1'b1;
        word  <= fifo.pop_front();
        idle = 0;
      end
      else
      begin
        valid <= 1'b0;
        word  <= ~word; // Released lines never keep the last word
        idle = idle + 1;
      end
    end
  end
endmodule

// file: verification/test_and_bitclear_condbranch_exec.sv
// Self-checking bench for the AND, bit clear and conditional branch executor
`timescale 1ns/100ps
module test_and_bitclear_condbranch_exec;
  // ****************************************
  // Signals, clock and instances
  // ****************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        valid;
  logic [15:0] word;
  logic        ready;
  logic [15:0] pc;
  logic [7:0]  w;
  logic [4:0]  st;
  logic [2:0]  radr = 3'h0;
  logic [7:0]  rwd = 8'h00;
  logic        rwr = 1'b0;
  logic        rrd = 1'b0;
  logic [7:0]  rdat;
  logic [3:0]  slow = 4'h0;
  logic [15:0] exp_pc = 16'h0000;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          takes = 0;
  int          last_take = 0;
  int          prev_take = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  and_bitclear_condbranch_exec i_and_bitclear_condbranch_exec
  (
    .SYS_CLK (clk), .RESET (rst), .INSTR_WORD (word), .INSTR_VALID (valid), .INSTR_READY (ready),
    .PC_OUT (pc), .W_OUT (w), .STATUS_OUT (st), .REG_ADDR (radr), .REG_WDATA (rwd),
    .REG_WR (rwr), .REG_RD (rrd), .REG_RDATA (rdat)
  );

  fetch_model i_fetch_model
  (
    .clk (clk), .rst (rst), .ready (ready), .slow (slow), .valid (valid), .word (word)
  );

  // Cycle count and time stamps of taken words
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (valid === 1'b1 && ready === 1'b1)
    begin
      takes     <= takes + 1;
      last_take <= cyc;
      prev_take <= last_take;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    rwr  <= 1'b1;
    radr <= a;
    rwd  <= d;
    @(posedge clk);
    rwr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    rrd  <= 1'b1;
    radr <= a;
    @(posedge clk);
    rrd <= 1'b0;
    @(posedge clk);
    d = rdat;
  endtask

  function automatic logic [15:0] andw(input logic d, input logic a, input logic [7:0] f);
    return {6'h05, d, a, f};
  endfunction

  // Issue one word; n is the cycles from its take until ready returns
  task automatic exec(input logic [15:0] wd, output int n);
    int k;
    k = takes + 1;
    i_fetch_model.load(wd);
    exp_pc = exp_pc + 16'h0002;
    for (int t = 0; t < 40 && takes != k; t++)
      @(posedge clk);
    for (int t = 0; t < 40 && ready !== 1'b1; t++)
      @(posedge clk);
    n = cyc - last_take;
  endtask

  // Two words queued together; g is the spacing of their takes
  task automatic pair(input logic [15:0] a, input logic [15:0] b, input int g);
    int k;
    k = takes + 2;
    i_fetch_model.load(a);
    i_fetch_model.load(b);
    exp_pc = exp_pc + 16'h0004;
    for (int t = 0; t < 60 && takes != k; t++)
      @(posedge clk);
    for (int t = 0; t < 40 && ready !== 1'b1; t++)
      @(posedge clk);
    chk(16'(last_take - prev_take), 16'(g));
    chk(pc, exp_pc);
  endtask

  // Clear cell through word a, read it back through word b
  task automatic same_cell(input logic [15:0] a, input logic [15:0] b);
    int n;
    reg_wr(3'h0, 8'h00);
    exec(a, n);
    reg_wr(3'h0, 8'hff);
    exec(b, n);
    chk(16'(w), 16'h0000);
  endtask

  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    chk(pc, 16'h0000);
    chk(16'(w), 16'h0000);
    chk(16'(st), 16'h0000);
    for (int a = 0; a < 8; a++)
    begin
      reg_rd(3'(a), d);
      chk(16'(d), 16'h0000);
    end
    reg_wr(3'h2, 8'hff);
    reg_rd(3'h2, d);
    chk(16'(d), 16'h000f);
    @(posedge clk);
    chk(16'(rdat), 16'h0000);
    reg_wr(3'h3, 8'h40);
    reg_wr(3'h4, 8'h12);
    reg_rd(3'h3, d);
    chk(16'(d), 16'h0040);
    reg_rd(3'h4, d);
    chk(16'(d), 16'h0012);
    chk(pc, 16'h1240);
    exp_pc = 16'h1240;
  endtask

  // Reset in mid-run returns the counter, working register, status and ready to their reset values
  task automatic t_rerst();
    reg_wr(3'h0, 8'ha5);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(pc, 16'h0000);
    chk(16'(w), 16'h0000);
    chk(16'(st), 16'h0000);
    chk(16'(ready), 16'h0001);
    exp_pc = 16'h0000;
  endtask

  task automatic t_and();
    int n;
    reg_wr(3'h2, 8'h03);
    reg_wr(3'h0, 8'h00);
    exec(andw(1'b1, 1'b1, 8'h10), n);
    chk(16'(n), 16'h0004);
    reg_wr(3'h0, 8'h5a);
    reg_wr(3'h1, 8'h1b);
    exec(andw(1'b1, 1'b1, 8'h10), n);
    chk(16'(w), 16'h005a);
    chk(16'(st), 16'h000f);
    reg_wr(3'h0, 8'hff);
    exec(andw(1'b0, 1'b1, 8'h10), n);
    chk(16'(w), 16'h0000);
    chk(pc, exp_pc);
  endtask

  task automatic t_clear();
    int n;
    for (int b = 0; b < 8; b++)
    begin
      reg_wr(3'h0, 8'h01 << b);
      reg_wr(3'h1, 8'h1b);
      exec({4'h9, 3'(b), 1'b0, 8'h20}, n);
      chk(16'(st), 16'h001b);
      chk(16'(n), 16'h0004);
      exec(andw(1'b0, 1'b0, 8'h20), n);
      chk(16'(w), 16'h0000);
      chk(16'(st), 16'h000f);
    end
  endtask

  task automatic t_addr();
    reg_wr(3'h2, 8'h00);
    same_cell(andw(1'b1, 1'b0, 8'h30), andw(1'b0, 1'b1, 8'h30));
    reg_wr(3'h2, 8'h0f);
    same_cell(andw(1'b1, 1'b0, 8'h80), andw(1'b0, 1'b1, 8'h80));
    reg_wr(3'h5, 8'h01);
    reg_wr(3'h6, 8'ha0);
    reg_wr(3'h7, 8'h02);
    same_cell(andw(1'b1, 1'b0, 8'h60), andw(1'b0, 1'b1, 8'h60));
    reg_wr(3'h2, 8'h02);
    same_cell(andw(1'b1, 1'b0, 8'h5f), andw(1'b0, 1'b1, 8'hff));
    reg_wr(3'h5, 8'h00);
  endtask

  task automatic t_branch();
    logic [7:0] ops [6] = '{8'he2, 8'he3, 8'he6, 8'he7, 8'he5, 8'he1};
    logic [7:0] offs [6] = '{8'h80, 8'h7f, 8'h05, 8'hfe, 8'h01, 8'h40};
    int         pos [6] = '{0, 0, 4, 4, 3, 2};
    bit         tv [6] = '{1, 0, 1, 0, 0, 0};
    logic [4:0] s;
    int         n;
    for (int i = 0; i < 6; i++)
      for (int tk = 0; tk < 2; tk++)
      begin
        s = ((tk == 1) == tv[i]) ? 5'(1 << pos[i]) : 5'(~(1 << pos[i]));
        reg_wr(3'h1, {3'h0, s});
        exec({ops[i], offs[i]}, n);
        if (tk == 1)
          exp_pc = exp_pc + {{7{offs[i][7]}}, offs[i], 1'b0};
        chk(pc, exp_pc);
        chk(16'(n), (tk == 1) ? 16'h0008 : 16'h0004);
        chk(16'(st), 16'(s));
      end
  endtask

  task automatic t_back();
    reg_wr(3'h1, 8'h00);
    pair(16'h0000, 16'hffff, 4);
    pair(16'he100, 16'h0000, 8);
    slow <= 4'h6;
    pair(16'h0000, 16'hffff, 8);
    slow <= 4'h0;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_and();
    t_clear();
    t_addr();
    t_branch();
    t_rerst();
    t_back();
    summarize();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
